// ---- gpc_pkg.sv ----
// Package for the gated pulse counter: word codes, field positions, timing.
// Assumes words arrive as 16-bit values, octal codes given as hex here.
package gpc_pkg;

    // ------------------------------------------------------------
    // Word formats
    // ------------------------------------------------------------
    localparam int          WORD_W            = 16;
    localparam int          COUNT_W           = 12;
    localparam logic [11:0] COUNT_MAX         = 12'hFFF;
    // Octal 10000 preset word, octal 170040/170160/170240 control words
    localparam logic [15:0] PRESET_WORD       = 16'h1000;
    localparam logic [15:0] CTRL_OUTPUT       = 16'hF020;
    localparam logic [15:0] CTRL_TIMING       = 16'hF070;
    localparam logic [15:0] CTRL_INPUT        = 16'hF0A0;
    localparam int          SYSTEM_ENABLE_POS = 5;
    localparam int          TRANSFER_EN_POS   = 4;
    localparam int          TIMING_MODE_POS   = 6;
    localparam int          INPUT_SELECT_POS  = 7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_MHZ           = 200;
    localparam int          MAX_PULSE_KHZ     = 200;
    localparam int          MIN_PULSE_CYC     = (CLK_MHZ * 1000) / (MAX_PULSE_KHZ * 2);
    // One gate unit is 1 ms, so gates of 10 ms up to 4.095 s fit a 12-bit word
    localparam int          GATE_UNIT_US      = 1000;
    localparam int          GATE_UNIT_CYC     = GATE_UNIT_US * CLK_MHZ;

    typedef enum logic [1:0] {
        GPC_IDLE   = 2'b00,
        GPC_OUTPUT = 2'b01,
        GPC_TIMING = 2'b10,
        GPC_INPUT  = 2'b11
    } gpc_mode_e;

endpackage

// ---- gpc_cnt_if.sv ----
// Interface between the control top and the counter core.
// Assumes one clock domain.
`timescale 1ns/1ps
interface gpc_cnt_if;
    logic        clear;
    logic        count_pulse;
    logic [11:0] count;
    modport ctrl (output clear, output count_pulse, input count);
    modport core (input clear, input count_pulse, output count);
endinterface

// ---- gpc_counter.sv ----
// Twelve-bit counter core, wrap modulo 4096, no overflow flag.
// Assumes count_pulse is a single-cycle pulse on mclk.
`timescale 1ns/1ps
module gpc_counter
    import gpc_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    gpc_cnt_if.core   cnt
);
    // Clear wins over a coincident pulse so a preset starts clean
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt.count <= 12'h000;
        end else if (cnt.clear) begin
            cnt.count <= 12'h000; // (RULE3)
        end else if (cnt.count_pulse) begin
            cnt.count <= cnt.count + 12'h001; // (RULE1) (RULE13)
        end
    end
endmodule

// ---- gpc_top.sv ----
// Gated pulse counter with its companion gate timer and word decoder.
// Assumes words come with a one-cycle strobe on mclk; pins are asynchronous.
//
// Function
// (RULE1) Count capacity is 4095 per measurement
// (RULE2) Count only while count enable active
// (RULE3) Preset word clears the count; code clears it in output mode only
// (RULE4) Output control word enters plain output mode
// (RULE5) Timing control word; next word gives gate
// (RULE6) Host waits for completion before input select
// (RULE7) Input select word enters input mode; read count
// (RULE8) Timing mode works only with strap fitted
// (RULE9) Count pulses up to 200 kHz
// (RULE10) External pulse gates reference counts for intervals
// (RULE11) Host picks gate from 10 ms upward
// (RULE12) Timing on raises service request; status clears
// (RULE13) Counter wraps modulo 4096, no overflow flag
`timescale 1ns/1ps
module gpc_top
    import gpc_pkg::*;
#(
    parameter int GATE_UNIT = GATE_UNIT_CYC
)(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        word_strobe,
    input  wire logic [15:0] word_data,
    input  wire logic        status_read,
    input  wire logic        pulse_in,
    input  wire logic        ext_enable_in,
    input  wire logic        use_ext_gate,
    input  wire logic        timing_option_strap,
    output logic [11:0]      count_value,
    output logic [1:0]       mode,
    output logic             gate_active,
    output logic             completion_flag,
    output logic             service_request
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] pulse_sync;
    logic [1:0] ext_sync;
    logic       pulse_prev;
    logic       strap;

    // Edge detector resets low, matching the idle pin, so no false edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pulse_sync <= 2'b00;
            ext_sync   <= 2'b00;
            pulse_prev <= 1'b0;
        end else begin
            pulse_sync <= {pulse_sync[0], pulse_in};
            ext_sync   <= {ext_sync[0], ext_enable_in};
            pulse_prev <= pulse_sync[1];
        end
    end

    // Strap is a pin too: two flops, no reset, so they are full at release
    logic [1:0] strap_sync;
    always_ff @(posedge mclk) begin
        strap_sync <= {strap_sync[0], timing_option_strap};
    end

    // Strap taken once after reset release, never inside the reset branch
    logic strap_taken;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            strap       <= 1'b0;
            strap_taken <= 1'b0;
        end else if (!strap_taken) begin
            strap       <= strap_sync[1]; // (RULE8)
            strap_taken <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Word decode
    // ------------------------------------------------------------
    gpc_mode_e   state;
    gpc_mode_e   next_state;
    logic        await_gate;
    logic [11:0] gate_left;
    logic [31:0] unit_cnt;

    // Last count of one gate unit, sized to the unit counter
    localparam logic [31:0] UNIT_LAST = 32'(GATE_UNIT - 1);

    // Control words carry all ones in the top nibble
    function automatic logic ctrl_word(input logic [15:0] w);
        return w[15:12] == CTRL_OUTPUT[15:12];
    endfunction

    // Exact match on one full control code
    function automatic logic code_is(input logic [15:0] w, input logic [15:0] code);
        return ctrl_word(w) && (w == code);
    endfunction

    // Strobe-qualified decodes, one name per word kind; then the gate timer terms
    wire is_ctrl      = word_strobe && ctrl_word(word_data);
    wire is_out_ctrl  = word_strobe && code_is(word_data, CTRL_OUTPUT);
    wire is_tim_ctrl  = word_strobe && code_is(word_data, CTRL_TIMING);
    wire is_in_ctrl   = is_ctrl && word_data[INPUT_SELECT_POS];
    wire is_data      = word_strobe && !is_ctrl;
    wire is_preset    = is_data && (state == GPC_OUTPUT) && (word_data == PRESET_WORD);
    wire is_gate_word = is_data && await_gate;
    wire gate_run     = gate_left != 12'h000;
    wire unit_done    = unit_cnt == UNIT_LAST;
    wire gate_end     = gate_run && unit_done && (gate_left == 12'h001);
    // Pulse edge after sync; 200 kHz gives ample margin over 5 ns sampling
    wire pulse_edge   = pulse_sync[1] && !pulse_prev; // (RULE9)
    wire count_en     = use_ext_gate ? ext_sync[1] : gate_run; // (RULE2) (RULE10)
    // Only a strapped timing word arms the gate; any data word disarms it
    wire next_await   = is_tim_ctrl ? strap : (is_data ? 1'b0 : await_gate); // (RULE5)

    // A timing word without the strap falls back to plain output mode
    always_comb begin
        next_state = state;
        if (is_tim_ctrl) begin
            next_state = strap ? GPC_TIMING : GPC_OUTPUT; // (RULE5) (RULE8)
        end else if (is_in_ctrl) begin
            next_state = GPC_INPUT; // (RULE7)
        end else if (is_out_ctrl) begin
            next_state = GPC_OUTPUT; // (RULE4)
        end
    end

    // ------------------------------------------------------------
    // Mode, gate timer and flags
    // ------------------------------------------------------------
    // Mode follows the decoded word one cycle later
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state      <= GPC_IDLE;
            await_gate <= 1'b0;
        end else begin
            state      <= next_state;
            await_gate <= next_await;
        end
    end

    // Gate length in 1 ms units; a word of zero gives no gate
    // Longest gate is 4095 units, just over four seconds
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gate_left <= 12'h000;
            unit_cnt  <= 32'h0;
        end else if (is_gate_word) begin
            gate_left <= word_data[11:0];
            unit_cnt  <= 32'h0;
        end else if (gate_run) begin
            unit_cnt  <= unit_done ? 32'h0 : unit_cnt + 32'h1;
            gate_left <= unit_done ? gate_left - 12'h001 : gate_left;
        end
    end

    // Completion set wins over a coincident clear by a new gate word
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            completion_flag <= 1'b0;
        end else if (gate_end) begin
            completion_flag <= 1'b1; // (RULE6)
        end else if (is_gate_word || is_in_ctrl) begin
            completion_flag <= 1'b0;
        end
    end

    // Service request raised by timing mode; set wins over status read
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            service_request <= 1'b0;
        end else if (is_tim_ctrl && strap) begin
            service_request <= 1'b1; // (RULE12)
        end else if (status_read) begin
            service_request <= 1'b0; // (RULE12)
        end
    end

    // ------------------------------------------------------------
    // Counter core
    // ------------------------------------------------------------
    // No overflow flag: the host must size the gate to stay under capacity
    gpc_cnt_if cnt_bus ();

    assign cnt_bus.clear       = is_preset; // (RULE3)
    assign cnt_bus.count_pulse = pulse_edge && count_en; // (RULE2)

    gpc_counter u_counter (
        .mclk (mclk),
        .rst  (rst),
        .cnt  (cnt_bus)
    );

    // Count is readable in any mode, no gate needed
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_value <= 12'h000;
        end else begin
            count_value <= cnt_bus.count; // (RULE7)
        end
    end

    // Mode shown one cycle after the state that holds it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode <= 2'b00;
        end else begin
            mode <= state;
        end
    end

    // Gate level for the host; lags the timer by one cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gate_active <= 1'b0;
        end else begin
            gate_active <= gate_run;
        end
    end

endmodule

// ---- gpc_top_sva.sv ----
// Checker for the gated pulse counter top, on its ports only.
// Assumes one mclk domain and an asynchronous active-high reset.
`timescale 1ns/1ps
module gpc_top_sva
    import gpc_pkg::*;
#(
    parameter int GATE_UNIT = GATE_UNIT_CYC
)(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        word_strobe,
    input wire logic [15:0] word_data,
    input wire logic        status_read,
    input wire logic        pulse_in,
    input wire logic        ext_enable_in,
    input wire logic        use_ext_gate,
    input wire logic        timing_option_strap,
    input wire logic [11:0] count_value,
    input wire logic [1:0]  mode,
    input wire logic        gate_active,
    input wire logic        completion_flag,
    input wire logic        service_request
);
    // ----------------------------------------
    // Helpers and assertions
    // ----------------------------------------
    logic [3:0]  idle_cyc;
    logic [11:0] gate_n;
    int          gate_len;
    wire         en_any = gate_active | (use_ext_gate & ext_enable_in) | word_strobe;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Idle count covers the pin synchroniser delay
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            idle_cyc <= 4'h0;
            gate_n   <= 12'h000;
            gate_len <= 0;
        end else begin
            idle_cyc <= en_any ? 4'h0 : idle_cyc + {3'h0, idle_cyc != 4'hF};
            if (word_strobe && mode == GPC_TIMING && word_data[15:12] != 4'hF) begin
                gate_n <= word_data[11:0];
            end
            gate_len <= gate_active ? gate_len + 1 : 0;
        end
    end
    AST_OUT_MODE: assert property (
        word_strobe && word_data == CTRL_OUTPUT |-> ##2 mode == GPC_OUTPUT)
        else $error("output word gave wrong mode");
    AST_IN_MODE: assert property (
        word_strobe && word_data[15:12] == 4'hF && word_data[7] |-> ##2 mode == GPC_INPUT)
        else $error("input word gave wrong mode");
    AST_TIMING: assert property (
        timing_option_strap && word_strobe && word_data == CTRL_TIMING
        |-> ##1 service_request ##1 mode == GPC_TIMING) else $error("timing word not taken");
    AST_NO_STRAP: assert property (
        !timing_option_strap && word_strobe && word_data == CTRL_TIMING
        |-> ##2 mode == GPC_OUTPUT && !service_request) else $error("timing without strap");
    AST_SRQ_CLR: assert property (
        status_read && !word_strobe |=> !service_request) else $error("status read kept request");
    AST_PRESET: assert property (
        mode == GPC_OUTPUT && word_strobe && word_data == PRESET_WORD |-> ##2 count_value == 0)
        else $error("preset did not clear count");
    AST_GATE_LEN: assert property (
        $fell(gate_active) |-> completion_flag && gate_len + 2 > gate_n * GATE_UNIT
        && gate_len < gate_n * GATE_UNIT + 2) else $error("gate length wrong");
    AST_NO_ENABLE: assert property (
        idle_cyc >= 4'h8 |-> $stable(count_value)) else $error("count moved without enable");
    AST_WRAP: assert property (
        $past(count_value) == COUNT_MAX && count_value != COUNT_MAX |-> count_value == 0)
        else $error("count did not wrap to zero");
endmodule
bind gpc_top gpc_top_sva #(.GATE_UNIT(GATE_UNIT)) gpc_top_sva_inst (
    .mclk(mclk), .rst(rst), .word_strobe(word_strobe), .word_data(word_data),
    .status_read(status_read), .pulse_in(pulse_in), .ext_enable_in(ext_enable_in),
    .use_ext_gate(use_ext_gate), .timing_option_strap(timing_option_strap),
    .count_value(count_value), .mode(mode), .gate_active(gate_active),
    .completion_flag(completion_flag), .service_request(service_request)
);

// ---- gpc_host_model.sv ----
// Host model: sends words and status reads, waits on completion.
// Assumes tasks are called just after a rising edge of mclk.
`timescale 1ns/1ps
module gpc_host_model (
    input  wire logic   mclk,
    input  wire logic   completion_flag,
    output logic        word_strobe,
    output logic [15:0] word_data,
    output logic        status_read
);
    // ----------------------------------------
    // Host tasks
    // ----------------------------------------
    initial begin
        word_strobe = 1'b0;
        word_data   = 16'h0000;
        status_read = 1'b0;
    end
    task automatic send(input logic [15:0] w);
        @(posedge mclk) #1;
        word_strobe = 1'b1;
        word_data   = w;
        @(posedge mclk) #1;
        word_strobe = 1'b0;
        word_data   = ~w; // Released bus never shows the old word
    endtask
    task automatic status_rd;
        @(posedge mclk) #1;
        status_read = 1'b1;
        @(posedge mclk) #1;
        status_read = 1'b0;
    endtask
    // Input select is held back until the gate has finished, for at most 5000 cycles
    task automatic wait_done(output logic late);
        int k;
        k = 0;
        while (completion_flag !== 1'b1 && k < 5000) begin
            @(posedge mclk) #1;
            k++;
        end
        late = (k >= 5000);
    endtask
endmodule

// ---- gpc_top_tb.sv ----
// Self-checking bench for the gated pulse counter top.
// Assumes gpc_host_model drives the word side; the pins are driven here.
`timescale 1ns/1ps
module gpc_top_tb
    import gpc_pkg::*;
;
    // ----------------------------------------
    // Bench
    // ----------------------------------------
    localparam int GU = 40;
    logic        mclk, rst, pulse_in, ext_en, use_ext, strap, look, late;
    wire logic   stb, srd, gate, done, srq;
    wire logic [15:0] wd;
    wire logic [11:0] cnt;
    wire logic [1:0]  md;
    int          err_total, compares, seed, n;
    typedef struct { int sel; logic [11:0] val; } gpc_note_s;
    gpc_note_s   notes[$];
    string       nm[5] = '{"count", "mode", "srq", "done", "gate"};
    gpc_top #(.GATE_UNIT(GU)) gpc_top_inst (.mclk(mclk), .rst(rst), .word_strobe(stb),
        .word_data(wd), .status_read(srd), .pulse_in(pulse_in), .ext_enable_in(ext_en),
        .use_ext_gate(use_ext), .timing_option_strap(strap), .count_value(cnt), .mode(md),
        .gate_active(gate), .completion_flag(done), .service_request(srq));
    gpc_host_model gpc_host_model_inst (.mclk(mclk), .completion_flag(done),
        .word_strobe(stb), .word_data(wd), .status_read(srd));
    function automatic logic [11:0] pick(input int s);
        pick = (s == 0) ? cnt : (s == 1) ? {10'h000, md} : (s == 2) ? {11'h000, srq}
             : (s == 3) ? {11'h000, done} : {11'h000, gate};
    endfunction
    always @(negedge mclk) begin
        if (look === 1'b1) begin
            compares++;
            if (notes[0].val !== pick(notes[0].sel)) begin
                err_total++;
                $display("BAD %s expected %h seen %h", nm[notes[0].sel], notes[0].val,
                         pick(notes[0].sel));
            end
            void'(notes.pop_front());
        end
    end
    task automatic expect_val(input int s, input logic [11:0] v);
        repeat (3) @(posedge mclk);
        #1 look = 1'b1;
        notes.push_back('{s, v});
        @(posedge mclk) #1;
        look = 1'b0;
    endtask
    task automatic pulses(input int c, input int w);
        repeat (c) begin
            pulse_in = 1'b1;
            repeat (w) @(posedge mclk);
            #1 pulse_in = 1'b0;
            repeat (w) @(posedge mclk);
            #1;
        end
    endtask
    task automatic do_reset(input logic s);
        strap = s;
        rst = 1'b1;
        repeat (5) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic close_out;
        if (err_total == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        {pulse_in, ext_en, use_ext, look, err_total, compares} = '0;
        seed = 32'he5bf;
        do_reset(1'b1);
        expect_val(1, 12'h000);
        gpc_host_model_inst.send(CTRL_OUTPUT);
        expect_val(1, {10'h000, GPC_OUTPUT});
        {use_ext, ext_en} = 2'b11;
        n = 1 + ($random(seed) & 7);
        pulses(n, MIN_PULSE_CYC);
        expect_val(0, n[11:0]);
        ext_en = 1'b0;
        pulses(3, 3);
        {use_ext, ext_en} = 2'b01;
        pulses(3, 3);
        expect_val(0, n[11:0]);
        gpc_host_model_inst.send(PRESET_WORD);
        expect_val(0, 12'h000);
        use_ext = 1'b1;
        pulses(4097, 3);
        expect_val(0, 12'h001);
        use_ext = 1'b0;
        gpc_host_model_inst.send(PRESET_WORD);
        gpc_host_model_inst.send(CTRL_TIMING);
        expect_val(2, 12'h001);
        expect_val(1, {10'h000, GPC_TIMING});
        gpc_host_model_inst.send(16'h000A);
        for (int k = 0; k < 100 && gate !== 1'b1; k++) @(posedge mclk) #1;
        pulses(10, 3);
        expect_val(4, 12'h001);
        gpc_host_model_inst.wait_done(late);
        if (late !== 1'b0) begin
            err_total++;
            $display("BAD completion_flag expected 1 seen %b", done);
        end
        expect_val(3, 12'h001);
        expect_val(4, 12'h000);
        gpc_host_model_inst.send(CTRL_INPUT);
        expect_val(1, {10'h000, GPC_INPUT});
        expect_val(3, 12'h000);
        expect_val(0, 12'h00A);
        gpc_host_model_inst.send(PRESET_WORD);
        expect_val(0, 12'h00A);
        gpc_host_model_inst.status_rd();
        expect_val(2, 12'h000);
        do_reset(1'b0);
        gpc_host_model_inst.send(CTRL_TIMING);
        expect_val(1, {10'h000, GPC_OUTPUT});
        expect_val(2, 12'h000);
        close_out();
    end
endmodule
